// ==== hw/irm_match_filter.sv ====
// isochronous receive context match filter with axi4-lite registers
//
// Functional notes
// [RQ1] label 11 accepted when bit 31 set
// [RQ2] label 10 accepted when bit 30 set
// [RQ3] label 01 accepted when bit 29 set
// [RQ4] label 00 accepted when bit 28 set
// [RQ5] bits 27 to 25 read zero
// [RQ6] cycle compare holds seconds and cycle index
// [RQ7] cycle compare enable delays start until match
// [RQ8] sync field compared when wait code 11
// [RQ9] bit 7 reads zero
// [RQ10] restriction: label 01 needs sync top 00
// [RQ11] restriction leaves other labels alone
// [RQ12] restriction clear: only label enables count
// [RQ13] lane field selects the accepted channel
// [RQ14] software starts context with run bit
// [RQ15] accept only when every test passes
`timescale 1ns/1ps
`default_nettype none

module irm_match_filter
  import irm_pkg::*;
(
  input wire logic clk, // core clock, 250 mhz
  input wire logic rst, // synchronous reset, active high
  // axi4-lite slave
  input wire logic [irm_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [irm_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  // link receive path
  input wire logic pkt_valid, // one-cycle packet header strobe
  input wire logic [5:0] pkt_lane, // channel of the packet
  input wire logic [1:0] pkt_label, // label field of the packet
  input wire logic [3:0] pkt_sync, // sync field of the packet
  // dma side
  input wire logic [1:0] desc_wait_code, // wait code of active descriptor
  input wire logic [31:0] bus_cycle_timer, // bus isochronous cycle timer
  output logic pkt_accept, // packet taken, one-cycle pulse
  output logic pkt_reject, // packet dropped, one-cycle pulse
  output logic ctx_active, // context receiving
  output logic ctx_waiting // context waiting for start cycle
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  irm_state_t s_reg;
  irm_state_t s_next;

  logic sync_wait;
  logic filter_pass;
  logic cycle_hit;
  logic [14:0] timer_now;
  logic [14:0] timer_want;

  // merge a write word into a register under byte strobes and mask
  function automatic logic [31:0] strobe_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0] strb,
    input logic [31:0] wmask
  );
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res & wmask;
  endfunction

  // -------------------------------------------------------------
  // cycle compare: low seconds bits then cycle index
  // -------------------------------------------------------------
  // the timer keeps seconds right above the index, so one compare
  assign timer_now = bus_cycle_timer[TMR_SEC_LSB+SEC_W-1:TMR_CNT_LSB]; // [RQ6]
  assign timer_want = {s_reg.match_sec, s_reg.match[CYC_MSB:CYC_LSB]}; // [RQ6]
  assign cycle_hit = (timer_now == timer_want); // [RQ7]

  // a sync wait is pending until one matching packet has been taken
  assign sync_wait = (desc_wait_code == WAIT_SYNC) && !s_reg.sync_done; // [RQ8]

  // -------------------------------------------------------------
  // per-packet decision
  // -------------------------------------------------------------
  irm_accept_check u_check (
    .match_filter(s_reg.match),
    .sync_wait(sync_wait),
    .pkt_lane(pkt_lane),
    .pkt_label(pkt_label),
    .pkt_sync(pkt_sync),
    .accept(filter_pass)
  );

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.acc_pulse = 1'b0;
    s_next.rej_pulse = 1'b0;

    // context sequencing
    case (s_reg.ctx)
      CTX_IDLE: begin
        if (s_reg.run) begin // [RQ14]
          s_next.ctx = s_reg.cyc_en ? CTX_WAIT_CYCLE : CTX_RECEIVE; // [RQ7]
        end
      end
      CTX_WAIT_CYCLE: begin
        if (!s_reg.run) begin
          s_next.ctx = CTX_IDLE;
        end else if (cycle_hit) begin
          // enable is spent once the start cycle is seen
          s_next.ctx = CTX_RECEIVE; // [RQ7]
          s_next.cyc_en = 1'b0;
        end
      end
      CTX_RECEIVE: begin
        if (!s_reg.run) begin
          s_next.ctx = CTX_IDLE;
        end
      end
      default: s_next.ctx = CTX_IDLE;
    endcase
    // state decodes kept in flops so the status outputs carry no logic
    s_next.active = (s_next.ctx == CTX_RECEIVE);
    s_next.waiting = (s_next.ctx == CTX_WAIT_CYCLE);

    // a new descriptor without the sync wait re-arms the wait
    if (desc_wait_code != WAIT_SYNC || !s_reg.run) begin
      s_next.sync_done = 1'b0;
    end

    // packet verdict; nothing is taken before the context runs
    if (pkt_valid) begin
      if (s_reg.ctx == CTX_RECEIVE && filter_pass) begin // [RQ15]
        s_next.acc_pulse = 1'b1;
        s_next.acc_cnt = s_reg.acc_cnt + 1'b1;
        if (sync_wait) begin
          s_next.sync_done = 1'b1; // [RQ8]
        end
      end else begin
        s_next.rej_pulse = 1'b1;
        s_next.rej_cnt = s_reg.rej_cnt + 1'b1;
      end
    end

    // write address and data channels, taken in either order
    if (s_axi_awvalid && s_reg.awready) begin
      s_next.have_aw = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_reg.wready) begin
      s_next.have_w = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_next.bvalid = 1'b0;
    end

    // perform the write once both halves are in; software wins over
    // the hardware updates above because it is applied last
    if (s_reg.have_aw && s_reg.have_w && !s_reg.bvalid) begin
      s_next.have_aw = 1'b0;
      s_next.have_w = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      case (s_reg.aw_addr)
        OFF_MATCH: begin
          // reserved bits 27..25 and 7 stay zero
          s_next.match = strobe_merge(s_reg.match, s_reg.w_data, s_reg.w_strb,
            MATCH_WMASK); // [RQ5] [RQ9]
        end
        OFF_CTRL: begin
          if (s_reg.w_strb[CTRL_RUN_BIT/8]) begin
            s_next.run = s_reg.w_data[CTRL_RUN_BIT]; // [RQ14]
          end
          if (s_reg.w_strb[CTRL_CYCEN_BIT/8]) begin
            s_next.cyc_en = s_reg.w_data[CTRL_CYCEN_BIT]; // [RQ7]
          end
        end
        OFF_MATCH_SEC: begin
          if (s_reg.w_strb[0]) begin
            s_next.match_sec = s_reg.w_data[SEC_W-1:0]; // [RQ6]
          end
        end
        OFF_STATUS: begin
          s_next.bresp = RESP_OKAY; // counters are read-only, write ignored
        end
        default: s_next.bresp = RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.have_aw && !s_next.bvalid;
    s_next.wready = !s_next.have_w && !s_next.bvalid;

    // read channel: one read at a time, data from the current state
    if (s_axi_rvalid && s_axi_rready) begin
      s_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_reg.arready) begin
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        OFF_MATCH: s_next.rdata = s_reg.match & MATCH_WMASK; // [RQ5] [RQ9]
        OFF_CTRL: begin
          s_next.rdata[CTRL_CYCEN_BIT] = s_reg.cyc_en;
          s_next.rdata[CTRL_RUN_BIT] = s_reg.run;
          s_next.rdata[CTRL_ACTIVE_BIT] = (s_reg.ctx == CTX_RECEIVE);
        end
        OFF_STATUS: s_next.rdata = {s_reg.rej_cnt, s_reg.acc_cnt};
        OFF_MATCH_SEC: s_next.rdata[SEC_W-1:0] = s_reg.match_sec;
        default: s_next.rresp = RESP_SLVERR;
      endcase
    end
    s_next.arready = !s_next.rvalid;
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg.match <= MATCH_RESET;
      s_reg.match_sec <= SEC_RESET;
      s_reg.run <= 1'b0;
      s_reg.cyc_en <= 1'b0;
      s_reg.ctx <= CTX_IDLE;
      s_reg.active <= 1'b0;
      s_reg.waiting <= 1'b0;
      s_reg.sync_done <= 1'b0;
      s_reg.acc_cnt <= '0;
      s_reg.rej_cnt <= '0;
      s_reg.acc_pulse <= 1'b0;
      s_reg.rej_pulse <= 1'b0;
      s_reg.have_aw <= 1'b0;
      s_reg.have_w <= 1'b0;
      s_reg.aw_addr <= '0;
      s_reg.w_data <= 32'h0000_0000;
      s_reg.w_strb <= 4'h0;
      s_reg.awready <= 1'b0;
      s_reg.wready <= 1'b0;
      s_reg.bvalid <= 1'b0;
      s_reg.bresp <= RESP_OKAY;
      s_reg.arready <= 1'b0;
      s_reg.rvalid <= 1'b0;
      s_reg.rdata <= 32'h0000_0000;
      s_reg.rresp <= RESP_OKAY;
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------
  // outputs, all straight from the state register
  // -------------------------------------------------------------
  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready = s_reg.wready;
  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;
  assign pkt_accept = s_reg.acc_pulse;
  assign pkt_reject = s_reg.rej_pulse;
  assign ctx_active = s_reg.active;
  assign ctx_waiting = s_reg.waiting;

endmodule
`default_nettype wire

// ==== hw/irm_pkg.sv ====
// shared constants and types of the isochronous receive match filter
package irm_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses on the axi4-lite slave)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_MATCH = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MATCH_SEC = 8'h0c;

  // ---------------------------------------------------------------
  // match filter fields
  // ---------------------------------------------------------------
  localparam int LBL11_BIT = 31;
  localparam int LBL10_BIT = 30;
  localparam int LBL01_BIT = 29;
  localparam int LBL00_BIT = 28;
  localparam int CYC_MSB = 24;
  localparam int CYC_LSB = 12;
  localparam int SYNC_MSB = 11;
  localparam int SYNC_LSB = 8;
  localparam int RESTRICT_BIT = 6;
  localparam int LANE_MSB = 5;
  localparam int LANE_LSB = 0;
  localparam logic [31:0] MATCH_WMASK = 32'hf1ff_ff7f;
  localparam logic [31:0] MATCH_RESET = 32'h0000_0000;

  // seconds extension of the cycle compare value
  localparam int SEC_W = 2;
  localparam logic [SEC_W-1:0] SEC_RESET = 2'h0;

  // ---------------------------------------------------------------
  // context control fields
  // ---------------------------------------------------------------
  localparam int CTRL_CYCEN_BIT = 29;
  localparam int CTRL_RUN_BIT = 15;
  localparam int CTRL_ACTIVE_BIT = 10;

  // ---------------------------------------------------------------
  // bus cycle timer fields
  // ---------------------------------------------------------------
  localparam int TMR_SEC_LSB = 25;
  localparam int TMR_CNT_MSB = 24;
  localparam int TMR_CNT_LSB = 12;

  // ---------------------------------------------------------------
  // codes
  // ---------------------------------------------------------------
  localparam logic [1:0] LABEL_11 = 2'h3;
  localparam logic [1:0] LABEL_10 = 2'h2;
  localparam logic [1:0] LABEL_01 = 2'h1;
  localparam logic [1:0] LABEL_00 = 2'h0;
  localparam logic [1:0] WAIT_SYNC = 2'h3;
  localparam logic [1:0] RESTRICT_TOP = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    CTX_IDLE,
    CTX_WAIT_CYCLE,
    CTX_RECEIVE
  } irm_ctx_t;

  // whole state of the top module
  typedef struct packed {
    logic [31:0] match;
    logic [SEC_W-1:0] match_sec;
    logic run;
    logic cyc_en;
    irm_ctx_t ctx;
    logic active;
    logic waiting;
    logic sync_done;
    logic [CNT_W-1:0] acc_cnt;
    logic [CNT_W-1:0] rej_cnt;
    logic acc_pulse;
    logic rej_pulse;
    logic have_aw;
    logic have_w;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } irm_state_t;

endpackage

// ==== hw/irm_accept_check.sv ====
// per-packet acceptance decision of the isochronous receive match filter
`timescale 1ns/1ps
`default_nettype none

module irm_accept_check
  import irm_pkg::*;
(
  input wire logic [31:0] match_filter, // current match register
  input wire logic sync_wait, // descriptor still waits for a sync value
  input wire logic [5:0] pkt_lane, // channel of the packet
  input wire logic [1:0] pkt_label, // label field of the packet
  input wire logic [3:0] pkt_sync, // sync field of the packet
  output logic accept // all tests pass
);

  logic lane_ok;
  logic label_ok;
  logic sync_ok;
  logic [3:0] sync_value;

  assign sync_value = match_filter[SYNC_MSB:SYNC_LSB];

  // channel test
  assign lane_ok = (pkt_lane == match_filter[LANE_MSB:LANE_LSB]); // [RQ13]

  // label enables; the restriction only touches label 01
  always_comb begin
    case (pkt_label)
      LABEL_11: label_ok = match_filter[LBL11_BIT]; // [RQ1] [RQ11]
      LABEL_10: label_ok = match_filter[LBL10_BIT]; // [RQ2] [RQ11]
      LABEL_01: begin
        label_ok = match_filter[LBL01_BIT]; // [RQ3]
        if (match_filter[RESTRICT_BIT]) begin
          label_ok = label_ok && (pkt_sync[3:2] == RESTRICT_TOP); // [RQ10] [RQ12]
        end
      end
      default: label_ok = match_filter[LBL00_BIT]; // [RQ4] [RQ11]
    endcase
  end

  // sync compare only while the descriptor asks for it
  assign sync_ok = !sync_wait || (pkt_sync == sync_value); // [RQ8]

  assign accept = lane_ok && label_ok && sync_ok; // [RQ15]

endmodule
`default_nettype wire

// ==== test/irm_match_filter_sva.sv ====
// port checker of the isochronous receive match filter
`timescale 1ns/1ps
`default_nettype none
module irm_match_filter_sva
  import irm_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic [1:0] s_axi_bresp, // b code
  input wire logic [irm_pkg::ADDR_W-1:0] s_axi_araddr, // ar address
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic pkt_valid, // header strobe
  input wire logic pkt_accept, // taken
  input wire logic pkt_reject, // dropped
  input wire logic ctx_active, // receiving
  input wire logic ctx_waiting // waiting for start cycle
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // which register a read answer belongs to, since araddr may move on
  logic [irm_pkg::ADDR_W-1:0] rd_addr_reg;
  always_ff @(posedge clk) begin
    if (s_axi_arvalid && s_axi_arready) rd_addr_reg <= s_axi_araddr;
  end
  // ----------------------------------------
  // bus and packet checks
  // ----------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wr_answer;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_wr_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write answer not two cycles after request");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_rsvd_zero: assert property (s_axi_rvalid && rd_addr_reg == OFF_MATCH
    |-> s_axi_rdata[27:25] == 3'h0 && !s_axi_rdata[7])
    else $error("reserved match bits not zero");
  a_one_verdict: assert property (pkt_valid |=> pkt_accept != pkt_reject)
    else $error("packet without exactly one verdict");
  a_no_verdict: assert property (!pkt_valid |=> !pkt_accept && !pkt_reject)
    else $error("verdict without packet");
  a_idle_reject: assert property (pkt_valid && !ctx_active |=> pkt_reject)
    else $error("packet taken while not receiving");
  a_state_excl: assert property (!(ctx_active && ctx_waiting))
    else $error("waiting and receiving together");
endmodule
bind irm_match_filter irm_match_filter_sva u_sva (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .pkt_valid,
  .pkt_accept, .pkt_reject, .ctx_active, .ctx_waiting);
`default_nettype wire

// ==== test/irm_link_model.sv ====
// link receive path model: header strobes and bus cycle timer
`timescale 1ns/1ps
`default_nettype none
module irm_link_model (
  input wire logic clk, // core clock
  input wire logic rst, // sync reset
  output logic pkt_valid, // header strobe
  output logic [5:0] pkt_lane, // channel
  output logic [1:0] pkt_label, // label
  output logic [3:0] pkt_sync, // sync
  output logic [31:0] bus_cycle_timer // seconds and cycle index
);
  initial begin
    pkt_valid = 0;
    pkt_lane = 0;
    pkt_label = 0;
    pkt_sync = 0;
  end
  // index steps every clock so start cycles come fast; carry runs into seconds
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_cycle_timer <= 32'h0000_0000;
    end else begin
      bus_cycle_timer <= bus_cycle_timer + 32'h0000_1000;
    end
  end
  // one header pulse; fields turn over after it so stale values never match
  task automatic send(logic [5:0] ln, logic [1:0] lb, logic [3:0] sy);
    @(posedge clk);
    pkt_lane <= ln;
    pkt_label <= lb;
    pkt_sync <= sy;
    pkt_valid <= 1;
    @(posedge clk);
    pkt_valid <= 0;
    pkt_lane <= ~ln;
    pkt_label <= ~lb;
    pkt_sync <= ~sy;
  endtask
endmodule
`default_nettype wire

// ==== test/irm_match_filter_tb.sv ====
// self-checking bench of the isochronous receive match filter
`timescale 1ns/1ps
`default_nettype none
module irm_match_filter_tb;
  import irm_pkg::*;
  logic clk = 0;
  logic rst = 1;
  logic [7:0] s_axi_awaddr = 0;
  logic [7:0] s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awvalid = 0;
  logic s_axi_wvalid = 0;
  logic s_axi_bready = 0;
  logic s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [1:0] desc_wait_code = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, bus_cycle_timer;
  logic pkt_valid, pkt_accept, pkt_reject, ctx_active, ctx_waiting;
  logic [5:0] pkt_lane;
  logic [1:0] pkt_label;
  logic [3:0] pkt_sync;
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // reference state: stored match word, receiving flag, sync wait done, counts
  logic [31:0] m_match = 0;
  bit m_run = 0;
  bit m_sdone = 0;
  int m_acc = 0;
  int m_rej = 0;
  always #2 clk = ~clk;
  irm_match_filter DUT (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pkt_valid, .pkt_lane, .pkt_label,
    .pkt_sync, .desc_wait_code, .bus_cycle_timer, .pkt_accept, .pkt_reject, .ctx_active,
    .ctx_waiting);
  irm_link_model link (.clk, .rst, .pkt_valid, .pkt_lane, .pkt_label, .pkt_sync,
    .bus_cycle_timer);
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // the whole run needs about seven hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      final_report;
    end
  end
  // ----------------------------------------
  // bus master and packet driver
  // ----------------------------------------
  task automatic axi_wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    // bready comes late on purpose so the answer has to stand a cycle
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1;
    end while (!(s_axi_bvalid && s_axi_bready));
    chk(s_axi_bresp, er);
    s_axi_bready <= 0;
  endtask
  task automatic axi_rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    // rready comes late on purpose so the read data has to stand a cycle
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1;
    end while (!(s_axi_rvalid && s_axi_rready));
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
    s_axi_rready <= 0;
  endtask
  function automatic bit exp_acc(logic [5:0] ln, logic [1:0] lb, logic [3:0] sy);
    bit sw;
    sw = desc_wait_code == WAIT_SYNC && !m_sdone;
    return m_run && ln == m_match[5:0] && m_match[28 + lb]
      && (lb != LABEL_01 || !m_match[6] || sy[3:2] == 2'h0)
      && (!sw || sy == m_match[11:8]);
  endfunction
  task automatic pkt(logic [5:0] ln, logic [1:0] lb, logic [3:0] sy);
    bit e;
    e = exp_acc(ln, lb, sy);
    link.send(ln, lb, sy);
    @(posedge clk);
    chk({pkt_accept, pkt_reject}, e ? 2'b10 : 2'b01);
    if (e) m_acc++;
    else m_rej++;
    if (e && desc_wait_code == WAIT_SYNC) m_sdone = 1;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [14:0] t;
    logic [14:0] dt;
    int n;
    void'($urandom(32'hd775));
    repeat (12) @(posedge clk);
    rst <= 0;
    for (int a = 0; a < 16; a += 4) axi_rd(8'(a), 32'h0, RESP_OKAY);
    axi_wr(OFF_MATCH, 32'hffff_ffff, RESP_OKAY);
    axi_rd(OFF_MATCH, 32'hf1ff_ff7f, RESP_OKAY);
    axi_wr(OFF_MATCH_SEC, 32'hffff_ffff, RESP_OKAY);
    axi_rd(OFF_MATCH_SEC, 32'h0000_0003, RESP_OKAY);
    axi_wr(8'h10, 32'h0000_0001, RESP_SLVERR);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    m_match = 32'hf1ff_ff7f;
    pkt(6'h3f, LABEL_11, 4'h0);
    axi_wr(OFF_CTRL, 32'h0000_8000, RESP_OKAY);
    m_run = 1;
    // random match words, every label in turn, lane hit about half the time
    for (int i = 0; i < 64; i++) begin
      d = $urandom;
      axi_wr(OFF_MATCH, d, RESP_OKAY);
      m_match = d & 32'hf1ff_ff7f;
      pkt($urandom_range(1) ? m_match[5:0] : 6'($urandom), 2'(i), 4'($urandom));
    end
    axi_wr(OFF_MATCH, 32'h3000_0045, RESP_OKAY);
    m_match = 32'h3000_0045;
    pkt(6'h05, LABEL_01, 4'h3);
    pkt(6'h05, LABEL_01, 4'h4);
    pkt(6'h05, LABEL_00, 4'h4);
    axi_wr(OFF_MATCH, 32'h1000_0505, RESP_OKAY);
    m_match = 32'h1000_0505;
    desc_wait_code <= WAIT_SYNC;
    @(posedge clk);
    pkt(6'h05, LABEL_00, 4'h3);
    pkt(6'h05, LABEL_00, 4'h5);
    pkt(6'h05, LABEL_00, 4'h3);
    desc_wait_code <= 2'h0;
    m_sdone = 0;
    // stop, then restart on a start cycle sixty cycles ahead
    axi_wr(OFF_CTRL, 32'h0, RESP_OKAY);
    m_run = 0;
    t = bus_cycle_timer[26:12] + 15'd60;
    m_match = {4'h8, 3'h0, t[12:0], 12'h005};
    axi_wr(OFF_MATCH, m_match, RESP_OKAY);
    axi_wr(OFF_MATCH_SEC, {30'h0, t[14:13]}, RESP_OKAY);
    axi_wr(OFF_CTRL, 32'h2000_8000, RESP_OKAY);
    @(posedge clk);
    chk(ctx_waiting, 1'b1);
    pkt(6'h05, LABEL_11, 4'h0);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!ctx_active && n < 200);
    dt = bus_cycle_timer[26:12] - t;
    chk(dt, 15'h0001);
    m_run = 1;
    pkt(6'h05, LABEL_11, 4'h0);
    axi_rd(OFF_CTRL, 32'h0000_8400, RESP_OKAY);
    axi_rd(OFF_STATUS, {m_rej[15:0], m_acc[15:0]}, RESP_OKAY);
    final_report;
  end
endmodule
`default_nettype wire
